/* File: src/lcdgp_defines.svh */
// Purpose: offsets, field positions, reset values for the shared lcd gpio ports
// Assumes: word-aligned 32-bit registers on an ahb-lite slave
// Notes: definitions only
`ifndef LCDGP_DEFINES_SVH
`define LCDGP_DEFINES_SVH

// ==========================================================
// register byte offsets
`define LCDGP_NARROW_DATA_OFS 8'h00
`define LCDGP_NARROW_DIR_OFS 8'h04
`define LCDGP_WIDE_DATA_OFS 8'h08
`define LCDGP_WIDE_DIR_OFS 8'h0c
`define LCDGP_LCD_ONE_OFS 8'h10
`define LCDGP_LCD_TWO_OFS 8'h14
`define LCDGP_STANDBY_OFS 8'h18
`define LCDGP_NARROW_LATCH_RD_OFS 8'h20
`define LCDGP_WIDE_LATCH_RD_OFS 8'h28

// ==========================================================
// field positions
`define LCDGP_SUPPLY_SEL_LSB 0
`define LCDGP_INPUT_GATE_BIT 4
`define LCDGP_PIN_FLOAT_BIT 0

// ==========================================================
// reset values
`define LCDGP_DIR4_RESET 4'h0
`define LCDGP_DIR8_RESET 8'h00
`define LCDGP_LATCH4_RESET 4'h0
`define LCDGP_LATCH8_RESET 8'h00
`define LCDGP_OE4_OFF 4'hf
`define LCDGP_OE8_OFF 8'hff

`endif

/* File: src/lcdgp_pkg.sv */
// Purpose: types for the shared lcd gpio ports
// Assumes: constants come from lcdgp_defines.svh
// Notes: the whole module state is one packed struct
package lcdgp_pkg;

	// ==========================================================
	// drive request from the lcd controller for the backplane pins
	typedef struct packed {
		logic [7:0] level;
		logic [7:0] drive;
	} lcdgp_com_drive_type;

	// ==========================================================
	// one pin group as seen at the pads
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe_n;
	} lcdgp_pad8_type;

	// ==========================================================
	// complete state of the block
	typedef struct packed {
		logic [3:0] narrow_port_data_latch;
		logic [3:0] narrow_port_direction;
		logic [7:0] wide_port_data_latch;
		logic [7:0] wide_port_direction;
		logic [3:0] lcd_supply_pin_select;
		logic port_input_gate;
		logic [7:0] backplane_output_select;
		logic standby_pin_float;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [3:0] narrow_sync1;
		logic [3:0] narrow_sync2;
		logic [7:0] wide_sync1;
		logic [7:0] wide_sync2;
		logic [31:0] rdata;
		logic [3:0] narrow_out;
		logic [3:0] narrow_oe_n;
		lcdgp_pad8_type wide_pad;
	} lcdgp_state_type;

endpackage

/* File: src/lcdgp_ports.sv */
// Purpose: 4-bit and 8-bit general purpose ports sharing pins with the lcd controller
// Assumes: ahb-lite single word transfers, one clock, standby request from the same clock
// Notes: all outputs except the tied-off hreadyout and hresp are registered; pin inputs pass two flip-flops
//
// Overview of operation
// - direction bit 1 output, 0 input
// - output pin drives its latch bit
// - data write updates latch, shows at once
// - write to input pin only updates latch
// - output pin read returns latch
// - input pin read returns sampled pin
// - latch-read access returns latch for inputs
// - bit 0 is low, 1 is high
// - reset clears both direction registers
// - float setting plus standby: all pins hi-z
// - floated pins read internally as low
// - float setting 0: standby changes nothing
// - supply select 0 gives pin to gpio
// - supply select 1 gives pin to supply
// - bits map onto pins in order
//
// Register access over AHB-Lite and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "lcdgp_defines.svh"

module lcdgp_ports (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// standby controller: stop or watch mode in effect
	input wire logic standby_stop_watch,
	// lcd controller backplane drive
	input wire lcdgp_pkg::lcdgp_com_drive_type lcd_com,
	// narrow port pads
	input wire logic [3:0] narrow_pin_in,
	output logic [3:0] narrow_pin_out,
	output logic [3:0] narrow_pin_oe_n,
	// wide port pads
	input wire logic [7:0] wide_pin_in,
	output logic [7:0] wide_pin_out,
	output logic [7:0] wide_pin_oe_n
);

	// ==========================================================
	// helpers

	// read value of one port: latch for outputs or latch reads, pin otherwise
	function automatic logic [7:0] port_read(
		input logic [7:0] latch,
		input logic [7:0] dir,
		input logic [7:0] sampled,
		input logic latch_read_instruction
	);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 8; i++) begin
			if (dir[i] || latch_read_instruction) begin
				r[i] = latch[i];
			end else begin
				r[i] = sampled[i];
			end
		end
		return r;
	endfunction

	// pad enable: low while a bit is driven and the pins are not floated
	function automatic logic [7:0] pad_oe_n(
		input logic [7:0] drive,
		input logic floated
	);
		logic [7:0] r;
		r = `LCDGP_OE8_OFF;
		if (!floated) begin
			r = ~drive;
		end
		return r;
	endfunction

	// ==========================================================
	// state

	lcdgp_pkg::lcdgp_state_type state_reg;
	lcdgp_pkg::lcdgp_state_type state_next;

	logic floated;
	logic addr_take;
	logic [7:0] rd_addr;
	logic [31:0] wdata;
	logic [7:0] narrow_in_path;
	logic [7:0] wide_in_path;
	logic [7:0] narrow_drive;
	logic [7:0] wide_drive;
	logic [7:0] wide_level;
	logic [7:0] narrow_oe_full;

	// next state: bus writes, reads, synchronisers and pad drive
	always_comb begin
		state_next = state_reg;
		wdata = hwdata;
		addr_take = hsel && htrans[1] && hready;
		rd_addr = haddr[7:0];
		floated = state_reg.standby_pin_float && standby_stop_watch;

		// pin synchronisers
		state_next.narrow_sync1 = narrow_pin_in;
		state_next.narrow_sync2 = state_reg.narrow_sync1;
		state_next.wide_sync1 = wide_pin_in;
		state_next.wide_sync2 = state_reg.wide_sync1;

		// data phase of a write lands in the registers
		if (state_reg.wr_pend) begin
			if (state_reg.wr_addr == `LCDGP_NARROW_DATA_OFS ||
				state_reg.wr_addr == `LCDGP_NARROW_LATCH_RD_OFS) begin
				state_next.narrow_port_data_latch = wdata[3:0];
			end else if (state_reg.wr_addr == `LCDGP_NARROW_DIR_OFS) begin
				state_next.narrow_port_direction = wdata[3:0];
			end else if (state_reg.wr_addr == `LCDGP_WIDE_DATA_OFS ||
				state_reg.wr_addr == `LCDGP_WIDE_LATCH_RD_OFS) begin
				state_next.wide_port_data_latch = wdata[7:0];
			end else if (state_reg.wr_addr == `LCDGP_WIDE_DIR_OFS) begin
				state_next.wide_port_direction = wdata[7:0];
			end else if (state_reg.wr_addr == `LCDGP_LCD_ONE_OFS) begin
				state_next.lcd_supply_pin_select = wdata[`LCDGP_SUPPLY_SEL_LSB +: 4];
				state_next.port_input_gate = wdata[`LCDGP_INPUT_GATE_BIT];
			end else if (state_reg.wr_addr == `LCDGP_LCD_TWO_OFS) begin
				state_next.backplane_output_select = wdata[7:0];
			end else if (state_reg.wr_addr == `LCDGP_STANDBY_OFS) begin
				state_next.standby_pin_float = wdata[`LCDGP_PIN_FLOAT_BIT];
			end
		end

		// address phase
		state_next.wr_pend = addr_take && hwrite;
		state_next.wr_addr = haddr[7:0];

		// internal input paths, blocked low while floated
		narrow_in_path = {4'h0, state_reg.narrow_sync2 & ~state_reg.lcd_supply_pin_select};
		wide_in_path = state_reg.port_input_gate ? state_reg.wide_sync2 : 8'h00;
		if (floated) begin
			narrow_in_path = 8'h00;
			wide_in_path = 8'h00;
		end

		// read data, built from the updated registers so read after write is current
		state_next.rdata = 32'h0000_0000;
		if (addr_take && !hwrite) begin
			if (rd_addr == `LCDGP_NARROW_DATA_OFS) begin
				state_next.rdata[7:0] = port_read({4'h0, state_next.narrow_port_data_latch},
					{4'h0, state_next.narrow_port_direction}, narrow_in_path, 1'b0);
			end else if (rd_addr == `LCDGP_NARROW_LATCH_RD_OFS) begin
				state_next.rdata[7:0] = port_read({4'h0, state_next.narrow_port_data_latch},
					{4'h0, state_next.narrow_port_direction}, narrow_in_path, 1'b1);
			end else if (rd_addr == `LCDGP_NARROW_DIR_OFS) begin
				state_next.rdata[3:0] = state_next.narrow_port_direction;
			end else if (rd_addr == `LCDGP_WIDE_DATA_OFS) begin
				state_next.rdata[7:0] = port_read(state_next.wide_port_data_latch,
					state_next.wide_port_direction, wide_in_path, 1'b0);
			end else if (rd_addr == `LCDGP_WIDE_LATCH_RD_OFS) begin
				state_next.rdata[7:0] = port_read(state_next.wide_port_data_latch,
					state_next.wide_port_direction, wide_in_path, 1'b1);
			end else if (rd_addr == `LCDGP_WIDE_DIR_OFS) begin
				state_next.rdata[7:0] = state_next.wide_port_direction;
			end else if (rd_addr == `LCDGP_LCD_ONE_OFS) begin
				state_next.rdata[`LCDGP_SUPPLY_SEL_LSB +: 4] = state_next.lcd_supply_pin_select;
				state_next.rdata[`LCDGP_INPUT_GATE_BIT] = state_next.port_input_gate;
			end else if (rd_addr == `LCDGP_LCD_TWO_OFS) begin
				state_next.rdata[7:0] = state_next.backplane_output_select;
			end else if (rd_addr == `LCDGP_STANDBY_OFS) begin
				state_next.rdata[`LCDGP_PIN_FLOAT_BIT] = state_next.standby_pin_float;
			end
		end

		// narrow port: gpio only while the supply select bit is 0
		narrow_drive = {4'h0, state_next.narrow_port_direction &
			~state_next.lcd_supply_pin_select};
		state_next.narrow_out = state_next.narrow_port_data_latch;
		narrow_oe_full = pad_oe_n(narrow_drive, floated);
		state_next.narrow_oe_n = narrow_oe_full[3:0]; // only four narrow pads exist

		// wide port: backplane select hands the pad to the lcd controller
		wide_drive = 8'h00;
		wide_level = 8'h00;
		for (int i = 0; i < 8; i++) begin
			if (state_next.backplane_output_select[i]) begin
				wide_drive[i] = lcd_com.drive[i];
				wide_level[i] = lcd_com.level[i];
			end else begin
				wide_drive[i] = state_next.wide_port_direction[i];
				wide_level[i] = state_next.wide_port_data_latch[i];
			end
		end
		state_next.wide_pad.out = wide_level;
		state_next.wide_pad.oe_n = pad_oe_n(wide_drive, floated);
	end

	// register the whole state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= '0;
			state_reg.narrow_port_direction <= `LCDGP_DIR4_RESET;
			state_reg.wide_port_direction <= `LCDGP_DIR8_RESET;
			state_reg.narrow_port_data_latch <= `LCDGP_LATCH4_RESET;
			state_reg.wide_port_data_latch <= `LCDGP_LATCH8_RESET;
			state_reg.narrow_oe_n <= `LCDGP_OE4_OFF;
			state_reg.wide_pad.oe_n <= `LCDGP_OE8_OFF;
		end else begin
			state_reg <= state_next;
		end
	end

	// ==========================================================
	// outputs, straight from the state flip-flops except the tied-off hreadyout and hresp
	assign hrdata = state_reg.rdata;
	assign hreadyout = 1'b1; // zero wait state slave
	assign hresp = 1'b0; // always okay
	assign narrow_pin_out = state_reg.narrow_out;
	assign narrow_pin_oe_n = state_reg.narrow_oe_n;
	assign wide_pin_out = state_reg.wide_pad.out;
	assign wide_pin_oe_n = state_reg.wide_pad.oe_n;

endmodule

`default_nettype wire

/* File: verification/lcdgp_pin_model.sv */
// Purpose: board side of the narrow and wide port pads
// Assumes: the board always drives a level through a series resistor
// Notes: a driven pad overrides the board level
`timescale 1ns/100ps
`default_nettype none

module lcdgp_pin_model (
	// pad side of the design
	input wire logic [3:0] n_out,
	input wire logic [3:0] n_oe_n,
	input wire logic [7:0] w_out,
	input wire logic [7:0] w_oe_n,
	// board levels
	input wire logic [3:0] ext_n,
	input wire logic [7:0] ext_w,
	// levels seen at the pads
	output logic [3:0] n_in,
	output logic [7:0] w_in
);
	// ==========================================================
	// wire level: the enabled driver wins, else the board level
	assign n_in = (n_out & ~n_oe_n) | (ext_n & n_oe_n);
	assign w_in = (w_out & ~w_oe_n) | (ext_w & w_oe_n);
endmodule
`default_nettype wire

/* File: verification/lcdgp_ports_monitor.sv */
// Purpose: port level checks of lcdgp_ports
// Assumes: zero wait state slave, pads registered on the data edge
// Notes: bound to every lcdgp_ports instance
`timescale 1ns/100ps
`default_nettype none

module lcdgp_ports_monitor (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// standby and lcd
	input wire logic standby_stop_watch,
	input wire lcdgp_pkg::lcdgp_com_drive_type lcd_com,
	// pads
	input wire logic [3:0] narrow_pin_in,
	input wire logic [3:0] narrow_pin_out,
	input wire logic [3:0] narrow_pin_oe_n,
	input wire logic [7:0] wide_pin_in,
	input wire logic [7:0] wide_pin_out,
	input wire logic [7:0] wide_pin_oe_n
);
	// ==========================================================
	// transfer decode
	logic wr_go;
	logic rd_go;
	assign wr_go = hsel & htrans[1] & hready & hwrite;
	assign rd_go = hsel & htrans[1] & hready & ~hwrite;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// ==========================================================
	// assertions
	a_wide_write_pad: assert property (wr_go && haddr[7:0] == 8'h08 |=> ##1
		((wide_pin_out ^ $past(hwdata[7:0])) & (wide_pin_out ^ $past(lcd_com.level))
		& ~wide_pin_oe_n) == 8'h00) else $error("wide pad differs from write");
	a_narrow_write_pad: assert property (wr_go && haddr[7:0] == 8'h00 |=> ##1
		((narrow_pin_out ^ $past(hwdata[3:0])) & ~narrow_pin_oe_n) == 4'h0)
		else $error("narrow pad differs from write");
	a_narrow_upper_zero: assert property (rd_go && haddr[7:0] inside {8'h00, 8'h04, 8'h20}
		|=> hrdata[31:4] == 28'h0) else $error("narrow upper bits not zero");
	a_wide_upper_zero: assert property (rd_go && haddr[7:0] inside {8'h08, 8'h0c, 8'h28}
		|=> hrdata[31:8] == 24'h0) else $error("wide upper bits not zero");
	a_unmapped_zero: assert property (rd_go && haddr[7:0] > 8'h28 |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_reset_hiz: assert property ($rose(hresetn) |-> narrow_pin_oe_n == 4'hf
		&& wide_pin_oe_n == 8'hff) else $error("pads driven after reset");
	a_oe_has_cause: assert property (!$stable(narrow_pin_oe_n) |-> $past(wr_go, 2)
		|| $past(standby_stop_watch) != $past(standby_stop_watch, 2))
		else $error("narrow enable moved without cause");
	a_latch_alias_read: assert property (rd_go && haddr[7:0] == 8'h20
		&& narrow_pin_oe_n == 4'h0 |=> hrdata[3:0] == narrow_pin_out)
		else $error("latch read differs from driven pads");
endmodule

bind lcdgp_ports lcdgp_ports_monitor i_lcdgp_ports_monitor (.hclk, .hresetn, .hsel, .haddr,
	.htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
	.standby_stop_watch, .lcd_com, .narrow_pin_in, .narrow_pin_out, .narrow_pin_oe_n,
	.wide_pin_in, .wide_pin_out, .wide_pin_oe_n);
`default_nettype wire

/* File: verification/lcdgp_ports_tb_top.sv */
// Purpose: self-checking bench of lcdgp_ports
// Assumes: ahb-lite master, board model on the pads
// Notes: random traffic from seed 75 plus corner cases
`timescale 1ns/100ps
`default_nettype none

module lcdgp_ports_tb_top;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, standby_stop_watch;
	logic [31:0] haddr, hwdata, hrdata, rd, v;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [3:0] narrow_pin_in, narrow_pin_out, narrow_pin_oe_n, ext_n, dn, ln;
	logic [7:0] wide_pin_in, wide_pin_out, wide_pin_oe_n, ext_w, dw, lw;
	logic [23:0] pads;
	lcdgp_pkg::lcdgp_com_drive_type lcd_com;
	integer seed, num_errors, check_count, i;
	assign hready = hreadyout;

	// ==========================================================
	// design, board and clock
	lcdgp_ports i_lcdgp_ports (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready, .hrdata, .hreadyout, .hresp, .standby_stop_watch, .lcd_com,
		.narrow_pin_in, .narrow_pin_out, .narrow_pin_oe_n, .wide_pin_in, .wide_pin_out,
		.wide_pin_oe_n);
	lcdgp_pin_model i_lcdgp_pin_model (.n_out(narrow_pin_out), .n_oe_n(narrow_pin_oe_n),
		.w_out(wide_pin_out), .w_oe_n(wide_pin_oe_n), .ext_n, .ext_w, .n_in(narrow_pin_in),
		.w_in(wide_pin_in));
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end

	// ==========================================================
	// bus cycle, checks and end
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		// address phase holds until hready is seen high at a rising edge
		do @(posedge hclk); while (!hready);
		htrans <= 2'h0;
		hwdata <= d;
		// data phase: read data taken at the edge where hready is high
		do @(posedge hclk); while (!hready);
		rd = hrdata;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	task automatic settle;
		repeat (3) @(posedge hclk);
		@(negedge hclk);
	endtask
	task automatic end_of_test;
		$display("checks %0d, mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge hclk);
		num_errors++;
		end_of_test;
	end

	// ==========================================================
	// main sequence
	initial begin
		{hresetn, hsel, haddr, htrans, hwrite, hwdata, standby_stop_watch} = '0;
		{lcd_com, ext_n, ext_w, num_errors, check_count} = '0;
		hsize = 3'h2;
		seed = 75;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		rc(8'h04, 32'h0);
		rc(8'h0c, 32'h0);
		chk({hreadyout, hresp, narrow_pin_oe_n, wide_pin_oe_n}, 32'h2fff);
		$display("reset test done");
		bus(1'b1, 8'h10, 32'h10); // gpio use, gate on
		for (i = 0; i < 24; i++) begin
			v = (i == 0) ? 32'hff0fff0f : $random(seed);
			{dw, lw, dn, ln} = {v[31:24], v[23:16], v[11:8], v[3:0]};
			bus(1'b1, 8'h00, v);
			bus(1'b1, 8'h04, v >> 8);
			bus(1'b1, 8'h08, v >> 16);
			bus(1'b1, 8'h0c, v >> 24);
			v = $random(seed);
			{ext_n, ext_w, lcd_com} <= v[27:0];
			settle;
			rc(8'h00, (ln & dn) | (ext_n & ~dn));
			rc(8'h08, (lw & dw) | (ext_w & ~dw));
			rc(8'h20, ln);
			rc(8'h28, lw);
			rc(8'h04, dn);
			chk({narrow_pin_oe_n, wide_pin_oe_n}, {~dn, ~dw});
			chk({narrow_pin_out & dn, wide_pin_out & dw}, {ln & dn, lw & dw});
		end
		$display("gpio test done");
		bus(1'b1, 8'h10, 32'h1f);
		settle;
		chk(narrow_pin_oe_n, 32'hf);
		bus(1'b1, 8'h04, 32'h0); // supply pins as inputs
		settle;
		rc(8'h00, 32'h0);
		bus(1'b1, 8'h10, 32'h10);
		bus(1'b1, 8'h04, {28'h0, dn});
		settle;
		chk(narrow_pin_oe_n, {~dn});
		bus(1'b1, 8'h0c, 32'h0);
		bus(1'b1, 8'h14, 32'hff);
		bus(1'b1, 8'h10, 32'h10); // gate set after select
		v = $random(seed);
		lcd_com <= v[15:0];
		settle;
		chk(wide_pin_oe_n, {~lcd_com.drive});
		chk(wide_pin_out & lcd_com.drive, {lcd_com.level & lcd_com.drive});
		bus(1'b1, 8'h14, 32'h0);
		bus(1'b1, 8'h0c, {24'h0, dw});
		$display("lcd test done");
		bus(1'b1, 8'h18, 32'h1);
		standby_stop_watch <= 1'b1;
		settle;
		chk({narrow_pin_oe_n, wide_pin_oe_n}, 32'hfff);
		rc(8'h00, ln & dn);
		rc(8'h08, lw & dw);
		standby_stop_watch <= 1'b0;
		bus(1'b1, 8'h18, 32'h0);
		settle;
		pads = {narrow_pin_out, narrow_pin_oe_n, wide_pin_out, wide_pin_oe_n};
		@(posedge hclk);
		standby_stop_watch <= 1'b1;
		settle;
		chk({narrow_pin_out, narrow_pin_oe_n, wide_pin_out, wide_pin_oe_n}, pads);
		rc(8'h30, 32'h0);
		$display("standby test done");
		// reset again with both directions set: they must clear
		hresetn <= 1'b0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		rc(8'h04, 32'h0);
		rc(8'h0c, 32'h0);
		chk({narrow_pin_oe_n, wide_pin_oe_n}, 32'hfff);
		$display("second reset test done");
		end_of_test;
	end
endmodule
`default_nettype wire
